//--- core/data_memory_map.sv
// Data memory map, status word, stack index and program vectors.
// Assumes the CPU core issues at most one access or stack step per cycle.
`timescale 1ns/1ps
`include "data_map_consts.svh"

// Overview of operation
// - Lower 128 RAM bytes reachable by direct and indirect addressing.
// - Indirect accesses at 128 to 255 go to the upper RAM bytes.
// - Direct accesses at 128 to 255 go only to special registers.
// - Lowest 32 bytes form four banks of eight working registers.
// - Bank bits select 00H, 08H, 10H or 18H as bank base.
// - Bytes 20H to 2FH hold bit addresses 00H to 7FH.
// - Special registers at addresses ending 0 or 8 are bit addressable.
// - Carry set on carry or borrow, cleared by other arithmetic.
// - Add and subtract set half carry on nibble carry or borrow, else clear it.
// - Overflow on signed overflow, product over 255, divide by zero.
// - Parity bit shows odd count of ones in accumulator.
// - Two free user flags at bits 5 and 1.
// - Stack index increments before each pushed byte is stored.
// - Stack index resets to 07H so first push lands at 08H.
// - Fetch starts at program address 0000H after reset.
// - Interrupt vectors at 0003H plus eight bytes per source.
// - Program memory is read only; no external program path.
// - Region access policy for boot, user and data flash.
// - Forbidden flash trigger is ignored and flash unchanged.
module data_memory_map (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        clk_en_i,
  input  wire logic                        acc_valid_i,
  input  wire logic                        acc_write_i,
  input  wire logic                        acc_indirect_i,
  input  wire logic                        acc_reg_mode_i,
  input  wire logic                        acc_bit_mode_i,
  input  wire logic [7:0]                  acc_addr_i,
  input  wire logic [7:0]                  acc_wdata_i,
  input  wire logic                        acc_bit_val_i,
  input  wire logic                        push_i,
  input  wire logic                        pop_i,
  input  wire data_map_pkg::arith_op_t     arith_op_i,
  input  wire logic [7:0]                  arith_a_i,
  input  wire logic [7:0]                  arith_b_i,
  input  wire logic [7:0]                  accum_i,
  input  wire logic [1:0]                  vector_sel_i,
  input  wire logic                        flash_trigger_i,
  input  wire logic                        flash_from_boot_i,
  input  wire logic                        flash_boot_data_en_i,
  input  wire data_map_pkg::flash_region_t flash_region_i,
  output logic [7:0]                       acc_rdata_o,
  output logic                             acc_rbit_o,
  output logic                             sfr_sel_o,
  output logic [7:0]                       sfr_addr_o,
  output logic [7:0]                       state_word_o,
  output logic [7:0]                       stack_top_index_o,
  output logic [15:0]                      fetch_addr_o,
  output logic [15:0]                      vector_addr_o,
  output logic                             flash_go_o
);

  logic [7:0]  ram_q [0:255];
  logic [7:0]  state_q;
  logic [7:0]  stack_q;
  logic [7:0]  rdata_q;
  logic        rbit_q;
  logic        sfr_sel_q;
  logic [7:0]  sfr_addr_q;
  logic [15:0] vector_q;
  logic        flash_go_q;

  // Byte address of a bit in the bit area; the bit within it is bit_pos
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    bit_byte = `BIT_AREA_BASE + {4'h0, a[6:3]};
  endfunction

  // Odd parity of a byte
  function automatic logic odd_ones(input logic [7:0] v);
    odd_ones = ^v;
  endfunction

  // Address decode for the access port
  wire        upper_half   = acc_addr_i >= `LOWER_LIMIT;
  wire [7:0]  bank_base    = {3'h0, state_q[`BIT_BANK_HI], state_q[`BIT_BANK_LO], 3'h0};
  wire [7:0]  reg_addr     = bank_base | {5'h00, acc_addr_i[2:0]};
  wire        to_sfr       = upper_half && !acc_indirect_i && !acc_reg_mode_i;
  wire [7:0]  sfr_bit_base = {acc_addr_i[7:3], 3'h0};
  wire        sfr_bit_ok   = (sfr_bit_base[2:0] == 3'h0);
  wire        bit_in_sfr   = acc_bit_mode_i && upper_half;
  wire [7:0]  bit_ram_addr = bit_byte(acc_addr_i);
  wire [7:0]  ram_addr     = acc_reg_mode_i ? reg_addr :
                             acc_bit_mode_i ? bit_ram_addr : acc_addr_i;
  wire        sfr_hit      = acc_bit_mode_i ? bit_in_sfr : to_sfr;
  wire [7:0]  sfr_target   = acc_bit_mode_i ? sfr_bit_base : acc_addr_i;
  wire        hit_state    = sfr_hit && sfr_target == `STATE_WORD_ADDR;
  wire        hit_stack    = sfr_hit && sfr_target == `STACK_INDEX_ADDR &&
                             !acc_bit_mode_i;
  wire        ram_hit      = !sfr_hit;
  wire [2:0]  bit_pos      = acc_addr_i[2:0];
  wire [7:0]  ram_byte     = ram_q[ram_addr];
  wire [7:0]  bit_mask     = 8'h01 << bit_pos;

  // Arithmetic flag results
  wire        carry_in     = state_q[`BIT_CARRY] && arith_op_i != data_map_pkg::ARITH_ADD;
  wire [8:0]  add_sum      = {1'b0, arith_a_i} + {1'b0, arith_b_i} + {8'h00, carry_in};
  wire [4:0]  add_nib      = {1'b0, arith_a_i[3:0]} + {1'b0, arith_b_i[3:0]} + {4'h0, carry_in};
  wire [8:0]  sub_dif      = {1'b0, arith_a_i} - {1'b0, arith_b_i} - {8'h00, carry_in};
  wire [4:0]  sub_nib      = {1'b0, arith_a_i[3:0]} - {1'b0, arith_b_i[3:0]} - {4'h0, carry_in};
  wire [15:0] mul_prod     = {8'h00, arith_a_i} * {8'h00, arith_b_i};
  wire        is_add       = arith_op_i == data_map_pkg::ARITH_ADD ||
                             arith_op_i == data_map_pkg::ARITH_ADDC;
  wire        is_sub       = arith_op_i == data_map_pkg::ARITH_SUBB;
  wire        add_ovf      = (arith_a_i[7] == arith_b_i[7]) && (add_sum[7] != arith_a_i[7]);
  wire        sub_ovf      = (arith_a_i[7] != arith_b_i[7]) && (sub_dif[7] != arith_a_i[7]);
  wire        arith_on     = arith_op_i != data_map_pkg::ARITH_NONE;

  // Stack index step with silent wrap in both directions
  wire [7:0]  stack_next   = push_i ? stack_q + 8'h01 :
                             pop_i  ? stack_q - 8'h01 : stack_q;

  // Flash trigger checked against the region policy
  flash_guard_if fg();
  assign fg.trigger      = flash_trigger_i;
  assign fg.from_boot    = flash_from_boot_i;
  assign fg.boot_data_en = flash_boot_data_en_i;
  assign fg.region       = flash_region_i;
  flash_guard u_guard (
    .g (fg)
  );

  // Next status word: software writes first, arithmetic then, parity always
  logic [7:0] state_d;
  always_comb begin
    state_d = state_q;
    if (clk_en_i && acc_valid_i && acc_write_i && hit_state) begin
      if (acc_bit_mode_i) begin
        state_d[bit_pos] = acc_bit_val_i;
      end else begin
        state_d = acc_wdata_i;
      end
    end
    if (is_add) begin
      state_d[`BIT_CARRY]      = add_sum[8];
      state_d[`BIT_HALF_CARRY] = add_nib[4];
      state_d[`BIT_WRAP]       = add_ovf;
    end else if (is_sub) begin
      state_d[`BIT_CARRY]      = sub_dif[8];
      state_d[`BIT_HALF_CARRY] = sub_nib[4];
      state_d[`BIT_WRAP]       = sub_ovf;
    end else if (arith_op_i == data_map_pkg::ARITH_MUL) begin
      state_d[`BIT_CARRY] = 1'b0;
      state_d[`BIT_WRAP]  = mul_prod > `MUL_LIMIT;
    end else if (arith_op_i == data_map_pkg::ARITH_DIV) begin
      state_d[`BIT_CARRY] = 1'b0;
      state_d[`BIT_WRAP]  = arith_b_i == 8'h00;
    end
    state_d[`BIT_PARITY] = odd_ones(accum_i);
  end

  // Status word and stack index registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= `STATE_WORD_RESET;
      stack_q <= `STACK_RESET;
    end else if (clk_en_i) begin
      state_q <= arith_on || acc_valid_i ? state_d : {state_q[7:1], state_d[0]};
      if (acc_valid_i && acc_write_i && hit_stack) begin
        stack_q <= acc_wdata_i;
      end else begin
        stack_q <= stack_next;
      end
    end
  end

  // Scratch-pad storage; SFR hits never touch it
  always_ff @(posedge clk_i) begin
    if (clk_en_i && acc_valid_i && acc_write_i && ram_hit) begin
      if (acc_bit_mode_i) begin
        ram_q[ram_addr] <= acc_bit_val_i ? (ram_byte | bit_mask) : (ram_byte & ~bit_mask);
      end else begin
        ram_q[ram_addr] <= acc_wdata_i;
      end
    end
  end

  // Read data, SFR forwarding, vectors and flash trigger
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q    <= 8'h00;
      rbit_q     <= 1'b0;
      sfr_sel_q  <= 1'b0;
      sfr_addr_q <= 8'h00;
      vector_q   <= `VECTOR_FIRST;
      flash_go_q <= 1'b0;
    end else if (clk_en_i) begin
      rdata_q    <= hit_state ? state_q : hit_stack ? stack_q :
                    sfr_hit ? 8'h00 : ram_byte;
      rbit_q     <= hit_state ? state_q[bit_pos] : ram_byte[bit_pos];
      sfr_sel_q  <= acc_valid_i && sfr_hit && (!acc_bit_mode_i || sfr_bit_ok) &&
                    !hit_state && !hit_stack;
      sfr_addr_q <= sfr_target;
      vector_q   <= `VECTOR_FIRST + ({14'h0000, vector_sel_i} << 3);
      flash_go_q <= fg.allowed;
    end
  end

  assign acc_rdata_o       = rdata_q;
  assign acc_rbit_o        = rbit_q;
  assign sfr_sel_o         = sfr_sel_q;
  assign sfr_addr_o        = sfr_addr_q;
  assign state_word_o      = state_q;
  assign stack_top_index_o = stack_q;
  assign fetch_addr_o      = `RESET_VECTOR;
  assign vector_addr_o     = vector_q;
  assign flash_go_o        = flash_go_q;

endmodule

//--- core/data_map_consts.svh
// Constants for the data memory map and status word block.
// Assumes inclusion by bare name from core files; definitions only.
`ifndef DATA_MAP_CONSTS_SVH
`define DATA_MAP_CONSTS_SVH
`define STATE_WORD_ADDR   8'hd0
`define STACK_INDEX_ADDR  8'h81
`define STACK_RESET       8'h07
`define STATE_WORD_RESET  8'h00
`define BIT_CARRY         7
`define BIT_HALF_CARRY    6
`define BIT_USER_ZERO     5
`define BIT_BANK_HI       4
`define BIT_BANK_LO       3
`define BIT_WRAP          2
`define BIT_USER_ONE      1
`define BIT_PARITY        0
`define LOWER_LIMIT       8'h80
`define BIT_AREA_BASE     8'h20
`define RESET_VECTOR      16'h0000
`define VECTOR_FIRST      16'h0003
`define VECTOR_STEP       16'h0008
`define MUL_LIMIT         16'h00ff
`endif

//--- core/data_map_pkg.sv
// Types shared by the data memory map block.
// Assumes constants come from data_map_consts.svh.
package data_map_pkg;
  typedef enum logic [2:0] {
    ARITH_NONE = 3'h0,
    ARITH_ADD  = 3'h1,
    ARITH_ADDC = 3'h2,
    ARITH_SUBB = 3'h3,
    ARITH_MUL  = 3'h4,
    ARITH_DIV  = 3'h5
  } arith_op_t;
  typedef enum logic [1:0] {
    REGION_USER = 2'h0,
    REGION_DATA = 2'h1,
    REGION_BOOT = 2'h2
  } flash_region_t;
endpackage

//--- core/flash_guard_if.sv
// Carrier between the data map top and its flash guard.
// Assumes one clock domain; plain signals only.
`timescale 1ns/1ps
interface flash_guard_if;
  logic                        trigger;
  logic                        from_boot;
  logic                        boot_data_en;
  data_map_pkg::flash_region_t region;
  logic                        allowed;
  modport top   (output trigger, output from_boot, output boot_data_en,
                 output region, input allowed);
  modport guard (input trigger, input from_boot, input boot_data_en,
                 input region, output allowed);
endinterface

//--- core/flash_guard.sv
// Flash region access check for a trigger request.
// Assumes the requester's program identity and region are presented with the trigger.
`timescale 1ns/1ps
module flash_guard (
  flash_guard_if.guard g
);
  // Region policy: user code only from boot, data from both, boot only from boot and if enabled
  assign g.allowed = g.trigger &&
    ((g.region == data_map_pkg::REGION_USER && g.from_boot) ||
     (g.region == data_map_pkg::REGION_DATA) ||
     (g.region == data_map_pkg::REGION_BOOT && g.from_boot && g.boot_data_en));
endmodule

//--- verification/data_map_assertions.sv
// Checker for the data memory map top ports.
// Assumes one clock domain and a bind onto data_memory_map.
`timescale 1ns/1ps
module data_map_assertions (
  input wire logic                        clk_i,
  input wire logic                        reset_n_i,
  input wire logic                        clk_en_i,
  input wire logic                        push_i,
  input wire logic                        pop_i,
  input wire data_map_pkg::arith_op_t     arith_op_i,
  input wire logic [7:0]                  arith_a_i,
  input wire logic [7:0]                  arith_b_i,
  input wire logic [7:0]                  accum_i,
  input wire logic [1:0]                  vector_sel_i,
  input wire logic                        flash_trigger_i,
  input wire logic                        flash_from_boot_i,
  input wire logic                        flash_boot_data_en_i,
  input wire data_map_pkg::flash_region_t flash_region_i,
  input wire logic [7:0]                  state_word_o,
  input wire logic [7:0]                  stack_top_index_o,
  input wire logic [15:0]                 fetch_addr_o,
  input wire logic [15:0]                 vector_addr_o,
  input wire logic                        flash_go_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Expected flag and policy outcomes
  wire [15:0] prod_w = {8'h00, arith_a_i} * {8'h00, arith_b_i};
  wire        big_w  = prod_w > 16'h00ff;
  wire        zero_w = arith_b_i == 8'h00;
  wire        par_w  = ^accum_i;
  wire        go_w   = (flash_region_i == data_map_pkg::REGION_DATA) || (flash_from_boot_i &&
    (flash_region_i == data_map_pkg::REGION_USER ||
    (flash_region_i == data_map_pkg::REGION_BOOT && flash_boot_data_en_i)));
  push_step_a: assert property (clk_en_i && push_i
    |=> stack_top_index_o == $past(stack_top_index_o) + 8'h01) else $error("push step wrong");
  pop_step_a: assert property (clk_en_i && pop_i && !push_i
    |=> stack_top_index_o == $past(stack_top_index_o) - 8'h01) else $error("pop step wrong");
  vector_map_a: assert property (clk_en_i
    |=> vector_addr_o == 16'h0003 + {11'h000, $past(vector_sel_i), 3'h0}) else $error("vector");
  fetch_start_a: assert property (fetch_addr_o == 16'h0000) else $error("fetch start");
  parity_track_a: assert property (clk_en_i
    |=> state_word_o[0] == $past(par_w)) else $error("parity wrong");
  mul_wrap_a: assert property (clk_en_i && arith_op_i == data_map_pkg::ARITH_MUL
    |=> state_word_o[2] == $past(big_w) && !state_word_o[7]) else $error("mul flags wrong");
  div_wrap_a: assert property (clk_en_i && arith_op_i == data_map_pkg::ARITH_DIV
    |=> state_word_o[2] == $past(zero_w)) else $error("div flag wrong");
  flash_policy_a: assert property (clk_en_i && flash_trigger_i
    |=> flash_go_o == $past(go_w)) else $error("flash policy wrong");
  // Main scenarios reached
  cover property (flash_go_o);
  cover property (push_i ##1 pop_i);
  cover property (arith_op_i == data_map_pkg::ARITH_MUL);
endmodule
bind data_memory_map data_map_assertions i_chk (.clk_i, .reset_n_i, .clk_en_i, .push_i,
  .pop_i, .arith_op_i, .arith_a_i, .arith_b_i, .accum_i, .vector_sel_i, .flash_trigger_i,
  .flash_from_boot_i, .flash_boot_data_en_i, .flash_region_i, .state_word_o,
  .stack_top_index_o, .fetch_addr_o, .vector_addr_o, .flash_go_o);

//--- verification/sfr_space_model.sv
// Model of the external special register space.
// Assumes the map's clock; records each forwarded direct access.
`timescale 1ns/1ps
module sfr_space_model (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       sfr_sel_i,
  input  wire logic [7:0] sfr_addr_i,
  output logic      [7:0] last_addr_o
);
  // Capture the address of a forwarded access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_addr_o <= 8'h00;
    end else if (sfr_sel_i) begin
      last_addr_o <= sfr_addr_i;
    end
  end
endmodule

//--- verification/data_memory_map_tb.sv
// Testbench for the data memory map block.
// Assumes the checker is bound and the external register model sits beside.
`timescale 1ns/1ps
module data_memory_map_tb;
  logic        clk_i, reset_n_i, clk_en_i, acc_valid_i, acc_write_i, acc_indirect_i;
  logic        acc_reg_mode_i, acc_bit_mode_i, acc_bit_val_i, push_i, pop_i, flash_trigger_i;
  logic        flash_from_boot_i, flash_boot_data_en_i, acc_rbit_o, sfr_sel_o, flash_go_o;
  logic [7:0]  acc_addr_i, acc_wdata_i, arith_a_i, arith_b_i, accum_i, acc_rdata_o, rd;
  logic [7:0]  sfr_addr_o, state_word_o, stack_top_index_o, last_addr;
  logic [15:0] fetch_addr_o, vector_addr_o;
  logic [1:0]  vector_sel_i;
  data_map_pkg::arith_op_t     arith_op_i;
  data_map_pkg::flash_region_t flash_region_i;
  int          err_total, tests_run;
  data_memory_map i_dut (.clk_i, .reset_n_i, .clk_en_i, .acc_valid_i, .acc_write_i,
    .acc_indirect_i, .acc_reg_mode_i, .acc_bit_mode_i, .acc_addr_i, .acc_wdata_i,
    .acc_bit_val_i, .push_i, .pop_i, .arith_op_i, .arith_a_i, .arith_b_i, .accum_i,
    .vector_sel_i, .flash_trigger_i, .flash_from_boot_i, .flash_boot_data_en_i,
    .flash_region_i, .acc_rdata_o, .acc_rbit_o, .sfr_sel_o, .sfr_addr_o, .state_word_o,
    .stack_top_index_o, .fetch_addr_o, .vector_addr_o, .flash_go_o);
  sfr_space_model i_sfr (.clk_i, .reset_n_i, .sfr_sel_i(sfr_sel_o), .sfr_addr_i(sfr_addr_o),
    .last_addr_o(last_addr));
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  // Control is write, indirect, register, bit; one idle cycle follows
  task automatic access(input logic [3:0] ctl, input logic [7:0] addr, input logic [7:0] data);
    {acc_valid_i, acc_write_i, acc_indirect_i, acc_reg_mode_i, acc_bit_mode_i} = {1'b1, ctl};
    {acc_addr_i, acc_wdata_i, acc_bit_val_i} = {addr, data, data[0]};
    tick();
    rd = acc_rdata_o;
    acc_valid_i = 1'b0;
    tick();
  endtask
  task automatic arith(input data_map_pkg::arith_op_t op, input logic [7:0] a, b,
                       input logic [2:0] exp, input logic [2:0] m);
    arith_op_i = op;
    {arith_a_i, arith_b_i} = {a, b};
    tick();
    check("cy hc ov", 16'(exp), 16'({state_word_o[7:6], state_word_o[2]} & m));
    arith_op_i = data_map_pkg::ARITH_NONE;
    tick();
  endtask
  initial begin
    {reset_n_i, clk_en_i, acc_valid_i, acc_write_i, acc_indirect_i, acc_reg_mode_i} = 6'h10;
    {acc_bit_mode_i, acc_bit_val_i, push_i, pop_i, flash_trigger_i, flash_from_boot_i} = 6'h00;
    {flash_boot_data_en_i, acc_addr_i, acc_wdata_i, arith_a_i, arith_b_i, accum_i} = 41'h0;
    arith_op_i = data_map_pkg::ARITH_NONE;
    flash_region_i = data_map_pkg::REGION_USER;
    {vector_sel_i, err_total, tests_run} = {2'h0, 64'h0};
    repeat (5) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    tick();
    check("state reset", 16'h0000, 16'(state_word_o));
    check("stack reset", 16'h0007, 16'(stack_top_index_o));
    check("fetch", 16'h0000, fetch_addr_o);
    for (int s = 0; s < 4; s++) begin
      vector_sel_i = s[1:0];
      tick();
      check("vector", 16'h0003 + 16'(s * 8), vector_addr_o);
    end
    access(4'h8, 8'h05, 8'haa);
    access(4'h4, 8'h05, 8'h00);
    check("indirect low", 16'h00aa, 16'(rd));
    access(4'hc, 8'h90, 8'h55);
    access(4'h8, 8'h90, 8'h66);
    check("sfr forward", 16'h0090, 16'(last_addr));
    access(4'h4, 8'h90, 8'h00);
    check("upper ram", 16'h0055, 16'(rd));
    for (int b = 0; b < 4; b++) begin
      access(4'h8, 8'hd0, 8'(b * 8) | 8'h22);
      check("state write", 16'(8'(b * 8) | 8'h22), 16'(state_word_o));
      access(4'ha, 8'h07, 8'h70 + 8'(b));
      access(4'h4, 8'(b * 8 + 7), 8'h00);
      check("bank reg", 16'h0070 + 16'(b), 16'(rd));
    end
    access(4'h8, 8'h21, 8'h00);
    access(4'h9, 8'h0a, 8'h01);
    access(4'h4, 8'h21, 8'h00);
    check("bit area", 16'h0004, 16'(rd));
    access(4'h1, 8'h0a, 8'h00);
    check("bit read", 16'h0001, 16'(acc_rbit_o));
    access(4'h1, 8'hb3, 8'h00);
    check("sfr bit base", 16'h00b0, 16'(last_addr));
    accum_i = 8'h07;
    tick();
    check("parity", 16'h0001, 16'(state_word_o[0]));
    accum_i = 8'h00;
    arith(data_map_pkg::ARITH_ADD, 8'hff, 8'h01, 3'h6, 3'h7);
    arith(data_map_pkg::ARITH_ADD, 8'h7f, 8'h01, 3'h3, 3'h7);
    arith(data_map_pkg::ARITH_ADD, 8'h12, 8'h34, 3'h0, 3'h7);
    arith(data_map_pkg::ARITH_SUBB, 8'h00, 8'h01, 3'h6, 3'h7);
    arith(data_map_pkg::ARITH_MUL, 8'h10, 8'h10, 3'h1, 3'h5);
    arith(data_map_pkg::ARITH_MUL, 8'h0f, 8'h11, 3'h0, 3'h5);
    arith(data_map_pkg::ARITH_DIV, 8'h08, 8'h00, 3'h1, 3'h5);
    arith(data_map_pkg::ARITH_DIV, 8'h08, 8'h02, 3'h0, 3'h5);
    push_i = 1'b1;
    tick();
    check("push", 16'h0008, 16'(stack_top_index_o));
    {push_i, pop_i} = 2'h1;
    tick();
    tick();
    check("pop", 16'h0006, 16'(stack_top_index_o));
    pop_i = 1'b0;
    access(4'h8, 8'h81, 8'hff);
    {push_i, clk_en_i} = 2'h2;
    tick();
    check("frozen", 16'h00ff, 16'(stack_top_index_o));
    clk_en_i = 1'b1;
    tick();
    check("wrap up", 16'h0000, 16'(stack_top_index_o));
    {push_i, pop_i} = 2'h1;
    tick();
    check("wrap down", 16'h00ff, 16'(stack_top_index_o));
    pop_i = 1'b0;
    for (int i = 0; i < 12; i++) begin
      {flash_from_boot_i, flash_boot_data_en_i, flash_trigger_i} = {i[1:0], 1'b1};
      flash_region_i = data_map_pkg::flash_region_t'(i[3:2]);
      tick();
      check("flash go", 16'((i[3:2] == 2'h1) || (i[1] && (i[3:2] == 2'h0 || i[0]))),
            16'(flash_go_o));
      flash_trigger_i = 1'b0;
      tick();
    end
    finish_test();
  end
endmodule
